// *** watchdog_pkg.sv ***
// Constants for the operating watchdog timer
package watchdog_pkg;
  // Register addresses
  localparam logic [15:0] CLEAR_PORT_ADDR = 16'hFFFF;
  localparam logic [15:0] CONFIG_ADDR     = 16'h0000;
  localparam logic [15:0] CAUSE_ADDR      = 16'h0001;
  localparam logic [15:0] MASK_ADDR       = 16'h0002;
  localparam logic [15:0] COUNT_ADDR      = 16'h0003;
  // Configuration fields
  localparam int          CFG_DISABLE_BIT = 0;
  localparam int          CFG_RATE_BIT    = 1;
  localparam int          CFG_PIN_EN_BIT  = 2;
  localparam logic [2:0]  CONFIG_RESET    = 3'h0;
  // Cause and mask fields
  localparam int          CAUSE_WDOG_BIT  = 0;
  localparam logic [0:0]  CAUSE_RESET     = 1'h0;
  localparam logic [0:0]  MASK_RESET      = 1'h0;
  // Counter widths and limits
  localparam int          PRESCALER_W     = 12;
  localparam int          WATCHDOG_W      = 6;
  localparam logic [11:0] PRESCALER_TOP   = 12'hFFF;
  localparam logic [11:0] CLEAR_KEEP_MASK = 12'h00F;
  localparam logic [11:0] OVERFLOW_PRE    = 12'hFEF;
  localparam logic [5:0]  LIMIT_LONG      = 6'h3F;
  localparam logic [5:0]  LIMIT_SHORT     = 6'h01;
  // Timing in oscillator cycles
  localparam int          POR_DELAY_OSC   = 4096;
  localparam int          RST_PULSE_OSC   = 32;
  localparam logic [12:0] POR_DELAY_CNT   = 13'(POR_DELAY_OSC);
  localparam logic [5:0]  RST_PULSE_CNT   = 6'(RST_PULSE_OSC);
endpackage

// *** operating_watchdog_timer.sv ***
// Watchdog timer with prescaler, reset pulse, cause flag and register port
// Summary of operation
// [RULE1] Six-bit watchdog advances on twelve-bit prescaler carry
// [RULE2] Overflow after 262128 or 8176 cycles forces reset
// [RULE3] Clear-port write zeroes watchdog and prescaler stages 12-5
// [RULE4] Reset sets cause flag, optionally pulls pin 32 cycles
// [RULE5] Clear-port read returns reset vector low byte
// [RULE6] Stop instruction clears the prescaler
// [RULE7] Prescaler cleared 4096 cycles after power up
// [RULE8] Internal reset clears prescaler and watchdog
// [RULE9] Disable follows first configuration register bit
// [RULE10] Prescaler counts raw oscillator clock
// [RULE11] Software services watchdog after reset and stop
// [RULE12] Software clears watchdog from main loop only
// [RULE13] Disabled watchdog neither resets nor sets cause
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module operating_watchdog_timer #(
  parameter int OSC_DIV = 1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  // Core events
  input  wire logic        stop_exec,
  input  wire logic        internal_reset,
  input  wire logic [7:0]  reset_vector_low,
  // Reset outputs
  output logic             sys_reset_req,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  // Status
  output logic             watchdog_disable,
  output logic             irq
);

  generate
    if (OSC_DIV < 1) begin : g_bad_div
      $error("OSC_DIV must be at least 1");
    end
  endgenerate

  localparam int DW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(OSC_DIV - 1);

  logic [DW-1:0]                              div_reg;
  logic                                       osc_tick;
  logic [watchdog_pkg::PRESCALER_W-1:0]       pre_reg;
  logic [watchdog_pkg::WATCHDOG_W-1:0]        wd_reg;
  logic [2:0]                                 config_reg;
  logic [0:0]                                 cause_reg;
  logic [0:0]                                 cause_next;
  logic [0:0]                                 mask_reg;
  logic [12:0]                                por_cnt_reg;
  logic                                       por_done_reg;
  logic                                       por_clear;
  logic [5:0]                                 pulse_cnt_reg;
  logic                                       pulse_active;
  logic                                       carry;
  logic [5:0]                                 limit;
  logic                                       overflow_evt;
  logic                                       clear_wr;
  logic                                       int_clear;

  // Oscillator rate as an enable; OSC_DIV of 1 counts every system clock
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_reg  <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (div_reg == DIV_LAST);
      div_reg  <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
    end
  end

  assign carry     = osc_tick && (pre_reg == watchdog_pkg::PRESCALER_TOP); // see [RULE1]
  assign limit     = config_reg[watchdog_pkg::CFG_RATE_BIT] ? watchdog_pkg::LIMIT_SHORT
                                                            : watchdog_pkg::LIMIT_LONG;
  // Overflow sixteen ticks short of the last carry, giving spans of 8176 or 262128 ticks
  assign overflow_evt = osc_tick && (pre_reg == watchdog_pkg::OVERFLOW_PRE)
                        && (wd_reg == limit) && !pulse_active
                        && !config_reg[watchdog_pkg::CFG_DISABLE_BIT]; // see [RULE2] see [RULE13]
  assign clear_wr  = wr_en && (addr == watchdog_pkg::CLEAR_PORT_ADDR);
  assign int_clear = internal_reset || overflow_evt || pulse_active;
  assign por_clear = osc_tick && !por_done_reg
                     && (por_cnt_reg == watchdog_pkg::POR_DELAY_CNT - 13'h0001);

  // Power-up delay before the prescaler receives its first clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      por_cnt_reg  <= 13'h0000;
      por_done_reg <= 1'b0;
    end else if (osc_tick && !por_done_reg) begin
      por_cnt_reg  <= por_cnt_reg + 13'h0001;
      por_done_reg <= por_clear;
    end
  end

  // Prescaler
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else if (int_clear || stop_exec || por_clear) begin
      pre_reg <= '0; // see [RULE6] see [RULE7] see [RULE8]
    end else if (clear_wr) begin
      pre_reg <= pre_reg & watchdog_pkg::CLEAR_KEEP_MASK; // see [RULE3]
    end else if (osc_tick) begin
      pre_reg <= pre_reg + 1'b1; // see [RULE10]
    end
  end

  // Watchdog counter; the written value is never looked at
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wd_reg <= '0;
    end else if (int_clear || clear_wr) begin
      wd_reg <= '0; // see [RULE3] see [RULE8]
    end else if (carry) begin
      wd_reg <= wd_reg + 1'b1; // see [RULE1]
    end
  end

  // Reset pulse of 32 oscillator cycles; the pin follows only when enabled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pulse_active  <= 1'b0;
      pulse_cnt_reg <= 6'h00;
      sys_reset_req <= 1'b0;
      rst_pin_oe    <= 1'b0;
      rst_pin_out   <= 1'b0;
    end else if (overflow_evt) begin
      pulse_active  <= 1'b1;
      pulse_cnt_reg <= 6'h00;
      sys_reset_req <= 1'b1; // see [RULE2]
      rst_pin_oe    <= config_reg[watchdog_pkg::CFG_PIN_EN_BIT]; // see [RULE4]
    end else if (pulse_active && osc_tick) begin
      if (pulse_cnt_reg == watchdog_pkg::RST_PULSE_CNT - 6'h01) begin
        pulse_active  <= 1'b0;
        sys_reset_req <= 1'b0;
        rst_pin_oe    <= 1'b0;
      end
      pulse_cnt_reg <= pulse_cnt_reg + 6'h01;
    end
  end

  // Configuration register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      config_reg       <= watchdog_pkg::CONFIG_RESET;
      watchdog_disable <= 1'b0;
    end else begin
      if (wr_en && addr == watchdog_pkg::CONFIG_ADDR) begin
        config_reg <= wr_data[2:0];
      end
      watchdog_disable <= config_reg[watchdog_pkg::CFG_DISABLE_BIT]; // see [RULE9]
    end
  end

  // Cause flag: write one to clear, a new event in the same cycle wins
  always_comb begin
    cause_next = cause_reg;
    if (wr_en && addr == watchdog_pkg::CAUSE_ADDR) begin
      cause_next = cause_next & ~wr_data[0:0];
    end
    if (overflow_evt) begin
      cause_next[watchdog_pkg::CAUSE_WDOG_BIT] = 1'b1; // see [RULE4]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cause_reg <= watchdog_pkg::CAUSE_RESET;
      mask_reg  <= watchdog_pkg::MASK_RESET;
      irq       <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      if (wr_en && addr == watchdog_pkg::MASK_ADDR) begin
        mask_reg <= wr_data[0:0];
      end
      irq <= |(cause_next & mask_reg);
    end
  end

  // Read port; the clear port shows the vector byte, not counter state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        watchdog_pkg::CLEAR_PORT_ADDR: rd_data <= reset_vector_low; // see [RULE5]
        watchdog_pkg::CONFIG_ADDR:     rd_data <= {5'h00, config_reg};
        watchdog_pkg::CAUSE_ADDR:      rd_data <= {7'h00, cause_reg};
        watchdog_pkg::MASK_ADDR:       rd_data <= {7'h00, mask_reg};
        watchdog_pkg::COUNT_ADDR:      rd_data <= {2'h0, wd_reg};
        default:                       rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence ovf_pin_s;
    overflow_evt && config_reg[watchdog_pkg::CFG_PIN_EN_BIT];
  endsequence
  sequence pin_low_s;
    rst_pin_oe [*8];
  endsequence

  // Counting and overflow
  carry_advance_a: assert property (
    carry && !int_clear && !clear_wr |=> wd_reg == $past(wd_reg) + 6'h01)
    else $error("watchdog did not advance on carry"); // see [RULE1]

  ovf_reset_a: assert property (overflow_evt |=> sys_reset_req && cause_reg[0])
    else $error("overflow gave no reset"); // see [RULE2]

  ovf_limit_a: assert property (overflow_evt
    |-> wd_reg == limit && pre_reg == watchdog_pkg::OVERFLOW_PRE)
    else $error("overflow at wrong count"); // see [RULE2]

  req_cause_a: assert property ($rose(sys_reset_req) |-> $past(overflow_evt))
    else $error("reset request without overflow"); // see [RULE2]

  pulse_hold_a: assert property (pulse_active |=> wd_reg == 6'h00 && pre_reg == 12'h000)
    else $error("counters ran during reset pulse"); // see [RULE8]

  clear_port_a: assert property (clear_wr && !int_clear && !stop_exec && !por_clear
    |=> wd_reg == 6'h00 && pre_reg[11:4] == 8'h00 && pre_reg[3:0] == $past(pre_reg[3:0]))
    else $error("clear write failed"); // see [RULE3]

  // Reset pulse, pin, cause flag and interrupt
  pin_pulse_a: assert property (ovf_pin_s |=> pin_low_s)
    else $error("reset pin pulse too short"); // see [RULE4]

  pin_enable_a: assert property ($rose(rst_pin_oe)
    |-> $past(config_reg[watchdog_pkg::CFG_PIN_EN_BIT]))
    else $error("pin driven while pin enable clear"); // see [RULE4]

  pin_level_a: assert property (rst_pin_out == 1'b0)
    else $error("reset pin driven high"); // see [RULE4]

  pulse_end_a: assert property (pulse_active && osc_tick
    && pulse_cnt_reg == watchdog_pkg::RST_PULSE_CNT - 6'h01
    |=> !sys_reset_req && !rst_pin_oe)
    else $error("reset pulse too long"); // see [RULE4]

  cause_clear_a: assert property (wr_en && addr == watchdog_pkg::CAUSE_ADDR && wr_data[0]
    && !overflow_evt |=> !cause_reg[0])
    else $error("cause flag not cleared"); // see [RULE4]

  irq_level_a: assert property (##1 irq == |(cause_reg & $past(mask_reg)))
    else $error("interrupt level wrong");

  // Register port
  vector_read_a: assert property (rd_en && addr == 16'hFFFF
    |=> rd_data == $past(reset_vector_low))
    else $error("clear port read wrong"); // see [RULE5]

  count_read_a: assert property (rd_en && addr == watchdog_pkg::COUNT_ADDR
    |=> rd_data == {2'h0, $past(wd_reg)})
    else $error("counter read wrong"); // see [RULE1]

  rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data outside read slot");

  config_write_a: assert property (wr_en && addr == watchdog_pkg::CONFIG_ADDR
    |=> config_reg == $past(wr_data[2:0]))
    else $error("config write lost"); // see [RULE9]

  mask_write_a: assert property (wr_en && addr == watchdog_pkg::MASK_ADDR
    |=> mask_reg == $past(wr_data[0:0]))
    else $error("mask write lost");

  // Clearing sources, disable and prescaler counting
  stop_clear_a: assert property (stop_exec |=> pre_reg == 12'h000)
    else $error("stop did not clear prescaler"); // see [RULE6]

  por_clear_a: assert property (por_clear |=> pre_reg == 12'h000 && por_done_reg)
    else $error("power-up clear missing"); // see [RULE7]

  int_reset_a: assert property (internal_reset |=> pre_reg == 12'h000 && wd_reg == 6'h00)
    else $error("internal reset did not clear"); // see [RULE8]

  disable_follow_a: assert property (##1 watchdog_disable == $past(config_reg[0]))
    else $error("disable does not follow config"); // see [RULE9]

  osc_count_a: assert property (osc_tick && !int_clear && !stop_exec && !por_clear
    && !clear_wr |=> pre_reg == $past(pre_reg) + 12'h001)
    else $error("prescaler missed a tick"); // see [RULE10]

  disabled_quiet_a: assert property (config_reg[0] && !cause_reg[0]
    && !(wr_en && addr == 16'h0000) |=> !cause_reg[0])
    else $error("cause set while disabled"); // see [RULE13]

endmodule

// *** core_model.sv ***
// Behavioural model of the processor core events seen by the watchdog
`timescale 1ns/1ps
module core_model #(
  parameter logic [7:0] VECTOR_LOW = 8'hA5
) (
  // Clock
  input  wire logic       clk_sys,
  // Requests from the test sequence
  input  wire logic       stop_req,
  input  wire logic       ireset_req,
  // Core event outputs
  output logic            stop_exec,
  output logic            internal_reset,
  output logic      [7:0] reset_vector_low
);
  // Vector byte is fixed by the program image, so it is a plain level
  assign reset_vector_low = VECTOR_LOW;
  // Stop is a single-cycle instruction event; software services the watchdog around it
  always_ff @(posedge clk_sys) begin
    stop_exec      <= stop_req;
    internal_reset <= ireset_req;
  end
endmodule

// *** operating_watchdog_timer_test.sv ***
// Self-checking bench for the operating watchdog timer
`timescale 1ns/1ps
module operating_watchdog_timer_test;
  logic        clk_sys, nrst, wr_en, rd_en, stop_req, ireset_req;
  logic [15:0] addr;
  logic [7:0]  wr_data, rd_data, vec;
  logic        stop_exec, internal_reset, sys_reset_req, rst_pin_out, rst_pin_oe;
  logic        watchdog_disable, irq;
  int          error_cnt, compares, hits, n;
  operating_watchdog_timer dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .stop_exec(stop_exec), .internal_reset(internal_reset), .reset_vector_low(vec),
    .sys_reset_req(sys_reset_req), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .watchdog_disable(watchdog_disable), .irq(irq));
  core_model core (.clk_sys(clk_sys), .stop_req(stop_req), .ireset_req(ireset_req),
    .stop_exec(stop_exec), .internal_reset(internal_reset), .reset_vector_low(vec));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Read data is registered, so it is sampled just after the following edge
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 check(rd_data, exp);
  endtask
  // Idle cycles while counting any forced reset cycles
  task idle(input int c);
    repeat (c) begin
      @(posedge clk_sys);
      #1 hits += int'(sys_reset_req !== 1'b0);
    end
  endtask
  task pulse_core(input logic s);
    @(posedge clk_sys);
    if (s) stop_req <= 1'b1; else ireset_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0; ireset_req <= 1'b0;
  endtask
  task wrap_up;
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(5ns * 60000);
    error_cnt++;
    wrap_up;
  end
  initial begin
    nrst = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 16'h0000; wr_data = 8'h00;
    stop_req = 1'b0; ireset_req = 1'b0; hits = 0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(watchdog_pkg::CONFIG_ADDR, 8'h00);
    rd(watchdog_pkg::CAUSE_ADDR, 8'h00);
    rd(watchdog_pkg::MASK_ADDR, 8'h00);
    rd(16'h0004, 8'h00);
    rd(watchdog_pkg::CLEAR_PORT_ADDR, 8'hA5);
    @(posedge clk_sys);
    #1 check(rd_data, 8'h00);
    idle(4200);
    // Short rate, pin enabled, interrupt unmasked; service right away
    wr(watchdog_pkg::CONFIG_ADDR, 8'h06);
    wr(watchdog_pkg::MASK_ADDR, 8'h01);
    wr(watchdog_pkg::CLEAR_PORT_ADDR, 8'h5A);
    rd(watchdog_pkg::COUNT_ADDR, 8'h00);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    // Low prescaler nibble survives the clear, so up to 15 ticks are lost
    check(8'(n >= 8158 && n <= 8180), 8'h01);
    check({6'h00, rst_pin_oe, rst_pin_out}, 8'h02);
    n = 0;
    while (sys_reset_req === 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(8'(n), 8'd32);
    check({7'h00, irq}, 8'h01);
    rd(watchdog_pkg::CAUSE_ADDR, 8'h01);
    wr(watchdog_pkg::CAUSE_ADDR, 8'h01);
    rd(watchdog_pkg::CAUSE_ADDR, 8'h00);
    check({7'h00, irq}, 8'h00);
    // Main-loop servicing keeps the short timeout from ever expiring
    wr(watchdog_pkg::CONFIG_ADDR, 8'h02);
    wr(watchdog_pkg::CLEAR_PORT_ADDR, 8'h00);
    hits = 0;
    repeat (3) begin
      idle(4000);
      wr(watchdog_pkg::CLEAR_PORT_ADDR, 8'hFF);
    end
    check(8'(hits), 8'h00);
    // Stop restarts the prescaler, delaying the next watchdog step
    idle(4000);
    pulse_core(1'b1);
    idle(200);
    rd(watchdog_pkg::COUNT_ADDR, 8'h00);
    idle(4000);
    rd(watchdog_pkg::COUNT_ADDR, 8'h01);
    pulse_core(1'b0);
    rd(watchdog_pkg::COUNT_ADDR, 8'h00);
    // Disabled watchdog runs but never forces a reset
    wr(watchdog_pkg::CONFIG_ADDR, 8'h03);
    wr(watchdog_pkg::CLEAR_PORT_ADDR, 8'h00);
    idle(2);
    check({7'h00, watchdog_disable}, 8'h01);
    hits = 0;
    idle(9000);
    check(8'(hits), 8'h00);
    rd(watchdog_pkg::CAUSE_ADDR, 8'h00);
    wrap_up;
  end
endmodule
